// *** mts_sequencer.sv ***
// Trigger and measurement-cycle sequencer with APB register access
//
// Behaviour
// - Three states: idle, waiting, measuring
// - Idle after power-up until started
// - Selected source event moves wait to measure
// - Stay measuring until done, leave at once
// - Continuous mode re-enters waiting after cycle
// - Count one: each start runs one cycle
// - Count above one: run that many cycles
// - Internal trigger waits configured delay first
// - Hold and bus sources trigger by command
// - Immediate source measures without waiting
// - Internal source compares input with level
// - Two external digital trigger inputs
// - Force command triggers any non-immediate source
// - Dropout timer restarts on every threshold crossing
// - Hold-off ignores events after accepted trigger
// - Repeat mode: result after average count
// - Moving mode: result after every measurement
// - Moving results unsettled until count reached
// - Measurement is two chopper phases
// - Sync high for repeat cycle or measurement
// - Cycle count reached returns to idle
// - Average one: single aperture, settled, idle
// - Single runs like continuous, not repeated
// - Abort: idle if single, waiting if continuous
// - Continuous off forces idle
// - Dropout needs signal on far side
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "mts_consts.svh"
`default_nettype none

module mts_sequencer #(
    parameter int CW = 32
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Trigger inputs from pins and the level comparator
    input wire logic int_above_i,
    input wire logic ext1_i,
    input wire logic ext2_i,
    // Sequencer outputs
    output logic sync_o,
    output logic [1:0] state_o,
    output logic chop_inv_o,
    output logic result_o,
    output logic settled_o
);

    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a[1:0] == 2'h0) && (a <= `MTS_OFF_RES);
    endfunction

    mts_pkg::mts_state_e state_r;
    mts_pkg::mts_state_e state_nxt;
    mts_pkg::mts_ctrl_s ctrl_r;
    logic [CW-1:0] cyc_r;
    logic [CW-1:0] avg_r;
    logic [CW-1:0] aper_r;
    logic [CW-1:0] dly_r;
    logic [CW-1:0] drop_r;
    logic [CW-1:0] hold_r;
    logic [CW-1:0] ap_cnt_r;
    logic [CW-1:0] rep_r;
    logic [CW-1:0] dly_cnt_r;
    logic [CW-1:0] drop_cnt_r;
    logic [CW-1:0] hold_cnt_r;
    logic [CW-1:0] cyc_done_r;
    logic [CW-1:0] mov_n_r;
    logic phase_r;
    logic dly_pend_r;
    logic result_r;
    logic settled_r;
    logic [31:0] prdata_r;
    logic [2:0] s1_r;
    logic [2:0] s2_r;
    logic [2:0] s3_r;
    logic [2:0] lvl_r;
    logic [2:0] lvl_q_r;
    logic wr;
    logic wr_ctrl;
    logic [`MTS_CMD_W-1:0] cmd_v;
    logic cont_on;
    logic cont_off;
    logic force_v;
    logic int_x;
    logic drop_ok;
    logic int_evt;
    logic src_evt;
    logic acc;
    logic go_meas;
    logic dly_done;
    logic ap_end;
    logic meas_end;
    logic cyc_end;
    logic res_evt;
    logic start;
    logic [31:0] rd_data;

    // APB decode; zero wait states
    assign wr = psel_i && penable_i && pwrite_i;
    assign wr_ctrl = wr && (paddr_i == `MTS_OFF_CTRL);
    assign cmd_v = (wr && paddr_i == `MTS_OFF_CMD) ? pwdata_i[`MTS_CMD_W-1:0] : '0;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !addr_hit(paddr_i);
    assign prdata_o = prdata_r;
    assign cont_on = wr_ctrl && pwdata_i[0] && !ctrl_r.cont;
    assign cont_off = wr_ctrl && !pwdata_i[0] && ctrl_r.cont;

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl_r <= mts_pkg::mts_ctrl_s'(`MTS_CTRL_RST);
            cyc_r <= CW'(`MTS_CYC_RST);
            avg_r <= CW'(`MTS_AVG_RST);
            aper_r <= CW'(`MTS_APER_RST);
            dly_r <= CW'(`MTS_DLY_RST);
            drop_r <= CW'(`MTS_DROPOUT_CYC);
            hold_r <= CW'(`MTS_HOLD_RST);
        end else if (wr) begin
            case (paddr_i)
                `MTS_OFF_CTRL: ctrl_r <= mts_pkg::mts_ctrl_s'(pwdata_i[`MTS_CTRL_W-1:0]);
                `MTS_OFF_CYC: cyc_r <= CW'(pwdata_i);
                `MTS_OFF_AVG: avg_r <= CW'(pwdata_i);
                `MTS_OFF_APER: aper_r <= CW'(pwdata_i);
                `MTS_OFF_DLY: dly_r <= CW'(pwdata_i);
                `MTS_OFF_DROP: drop_r <= CW'(pwdata_i);
                `MTS_OFF_HOLD: hold_r <= CW'(pwdata_i);
                default: ;
            endcase
        end
    end

    always_comb begin
        rd_data = 32'h00000000;
        case (paddr_i)
            `MTS_OFF_CTRL: rd_data = 32'(ctrl_r);
            `MTS_OFF_CYC: rd_data = 32'(cyc_r);
            `MTS_OFF_AVG: rd_data = 32'(avg_r);
            `MTS_OFF_APER: rd_data = 32'(aper_r);
            `MTS_OFF_DLY: rd_data = 32'(dly_r);
            `MTS_OFF_DROP: rd_data = 32'(drop_r);
            `MTS_OFF_HOLD: rd_data = 32'(hold_r);
            `MTS_OFF_STAT: rd_data = {26'h0, settled_r, dly_pend_r, phase_r,
                                      (hold_cnt_r != '0), state_r};
            `MTS_OFF_RES: rd_data = 32'(cyc_done_r);
            default: rd_data = 32'h00000000;
        endcase
    end

    // Read data is sampled in the setup phase so it is steady in the access phase
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prdata_r <= 32'h00000000;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            prdata_r <= rd_data;
        end
    end

    // Three-stage input capture; a level counts once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            always_ff @(posedge mclk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    s1_r[gi] <= 1'b0;
                    s2_r[gi] <= 1'b0;
                    s3_r[gi] <= 1'b0;
                    lvl_r[gi] <= 1'b0;
                    lvl_q_r[gi] <= 1'b0;
                end else begin
                    s1_r[gi] <= (gi == 0) ? int_above_i : (gi == 1) ? ext1_i : ext2_i;
                    s2_r[gi] <= s1_r[gi];
                    s3_r[gi] <= s2_r[gi];
                    if (s2_r[gi] == s3_r[gi]) begin
                        lvl_r[gi] <= s3_r[gi];
                    end
                    lvl_q_r[gi] <= lvl_r[gi];
                end
            end
        end
    endgenerate

    // Internal trigger: crossing in the chosen slope after a full dropout interval
    assign int_x = lvl_r[0] != lvl_q_r[0];
    assign drop_ok = drop_cnt_r >= drop_r;
    assign int_evt = int_x && drop_ok && (lvl_r[0] != ctrl_r.slope_neg);

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            drop_cnt_r <= '0;
        end else if (int_x) begin
            drop_cnt_r <= '0;
        end else if (!drop_ok) begin
            drop_cnt_r <= drop_cnt_r + CW'(1);
        end
    end

    always_comb begin
        case (ctrl_r.src)
            mts_pkg::MTS_SRC_INT: src_evt = int_evt;
            mts_pkg::MTS_SRC_EXT1: src_evt = lvl_r[1] && !lvl_q_r[1];
            mts_pkg::MTS_SRC_EXT2: src_evt = lvl_r[2] && !lvl_q_r[2];
            mts_pkg::MTS_SRC_BUS: src_evt = cmd_v[`MTS_CMD_BUSTRG];
            default: src_evt = 1'b0;
        endcase
    end

    assign force_v = cmd_v[`MTS_CMD_FORCE] && (ctrl_r.src != mts_pkg::MTS_SRC_IMM);
    assign dly_done = dly_pend_r && (dly_cnt_r + CW'(1) >= dly_r);

    // Phase timing; an aperture of zero is treated as one cycle
    assign ap_end = ap_cnt_r + CW'(1) >= aper_r;
    assign meas_end = ap_end && (phase_r || avg_r <= CW'(1));
    assign cyc_end = meas_end && (ctrl_r.moving || avg_r <= CW'(1)
                     || rep_r + CW'(1) >= avg_r);
    assign res_evt = (state_r == mts_pkg::MTS_MEAS) && cyc_end
                     && !cmd_v[`MTS_CMD_ABORT] && !cont_off;
    assign start = (state_r == mts_pkg::MTS_IDLE) && (state_nxt == mts_pkg::MTS_WAIT);

    always_comb begin
        state_nxt = state_r;
        go_meas = 1'b0;
        acc = 1'b0;
        if (cmd_v[`MTS_CMD_ABORT]) begin
            state_nxt = ctrl_r.cont ? mts_pkg::MTS_WAIT : mts_pkg::MTS_IDLE;
        end else if (cont_off) begin
            state_nxt = mts_pkg::MTS_IDLE;
        end else begin
            case (state_r)
                mts_pkg::MTS_IDLE: begin
                    if (cont_on || cmd_v[`MTS_CMD_INIT]) begin
                        state_nxt = mts_pkg::MTS_WAIT;
                    end
                end
                mts_pkg::MTS_WAIT: begin
                    if (ctrl_r.src == mts_pkg::MTS_SRC_IMM || force_v || dly_done) begin
                        go_meas = 1'b1;
                    end else if (src_evt && !dly_pend_r && hold_cnt_r == '0) begin
                        acc = 1'b1;
                        go_meas = (dly_r == '0);
                    end
                    if (go_meas) begin
                        state_nxt = mts_pkg::MTS_MEAS;
                    end
                end
                mts_pkg::MTS_MEAS: begin
                    if (res_evt) begin
                        if (ctrl_r.cont || cyc_done_r + CW'(1) < cyc_r) begin
                            state_nxt = mts_pkg::MTS_WAIT;
                        end else begin
                            state_nxt = mts_pkg::MTS_IDLE;
                        end
                    end
                end
                default: state_nxt = mts_pkg::MTS_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_r <= mts_pkg::MTS_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Trigger delay and hold-off timers
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            dly_pend_r <= 1'b0;
            dly_cnt_r <= '0;
        end else if (state_nxt != mts_pkg::MTS_WAIT || go_meas) begin
            dly_pend_r <= 1'b0;
            dly_cnt_r <= '0;
        end else if (acc) begin
            dly_pend_r <= 1'b1;
            dly_cnt_r <= '0;
        end else if (dly_pend_r) begin
            dly_cnt_r <= dly_cnt_r + CW'(1);
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            hold_cnt_r <= '0;
        end else if (acc) begin
            hold_cnt_r <= hold_r;
        end else if (hold_cnt_r != '0) begin
            hold_cnt_r <= hold_cnt_r - CW'(1);
        end
    end

    // Chopper phases and repetitions inside a measurement
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ap_cnt_r <= '0;
            phase_r <= 1'b0;
            rep_r <= '0;
        end else if (state_nxt != mts_pkg::MTS_MEAS || state_r != mts_pkg::MTS_MEAS) begin
            ap_cnt_r <= '0;
            phase_r <= 1'b0;
            rep_r <= '0;
        end else if (ap_end) begin
            ap_cnt_r <= '0;
            if (meas_end) begin
                phase_r <= 1'b0;
                rep_r <= rep_r + CW'(1);
            end else begin
                phase_r <= 1'b1;
            end
        end else begin
            ap_cnt_r <= ap_cnt_r + CW'(1);
        end
    end

    // Result bookkeeping
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cyc_done_r <= '0;
            mov_n_r <= '0;
        end else if (start || cmd_v[`MTS_CMD_ABORT]) begin
            cyc_done_r <= start ? '0 : cyc_done_r;
            mov_n_r <= '0;
        end else if (res_evt) begin
            cyc_done_r <= cyc_done_r + CW'(1);
            if (mov_n_r < avg_r) begin
                mov_n_r <= mov_n_r + CW'(1);
            end
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            result_r <= 1'b0;
            settled_r <= 1'b0;
        end else begin
            result_r <= res_evt;
            if (res_evt) begin
                settled_r <= !ctrl_r.moving || mov_n_r + CW'(1) >= avg_r;
            end
        end
    end

    // Sync follows the measuring state, which spans the whole repeat cycle
    assign sync_o = ctrl_r.sync_en && (state_r == mts_pkg::MTS_MEAS);
    assign state_o = state_r;
    assign chop_inv_o = phase_r;
    assign result_o = result_r;
    assign settled_o = settled_r;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    abort_single_idle_a: assert property (cmd_v[`MTS_CMD_ABORT] && !ctrl_r.cont
        |=> state_r == mts_pkg::MTS_IDLE && !sync_o)
        else $error("abort in single mode did not go idle");

    cont_off_idle_a: assert property (cont_off && !cmd_v[`MTS_CMD_ABORT]
        |=> state_r == mts_pkg::MTS_IDLE)
        else $error("continuous off did not go idle");

    imm_source_meas_a: assert property (state_r == mts_pkg::MTS_WAIT
        && ctrl_r.src == mts_pkg::MTS_SRC_IMM && cmd_v == '0 && !wr_ctrl
        |=> state_r == mts_pkg::MTS_MEAS)
        else $error("immediate source did not start measuring");

    holdoff_ignore_a: assert property (state_r == mts_pkg::MTS_WAIT
        && hold_cnt_r != '0 && !dly_pend_r && !force_v
        && ctrl_r.src != mts_pkg::MTS_SRC_IMM
        |=> state_r != mts_pkg::MTS_MEAS && !dly_pend_r)
        else $error("trigger accepted during hold-off");

    dropout_gate_a: assert property (state_r == mts_pkg::MTS_WAIT
        && ctrl_r.src == mts_pkg::MTS_SRC_INT && int_x && !drop_ok
        && !force_v && !dly_pend_r
        |=> state_r != mts_pkg::MTS_MEAS && !dly_pend_r && drop_cnt_r == '0)
        else $error("internal trigger before dropout elapsed");

    chop_two_phase_a: assert property (state_r == mts_pkg::MTS_MEAS
        && !phase_r && ap_end && avg_r > CW'(1) && state_nxt == mts_pkg::MTS_MEAS
        |=> phase_r ##0 chop_inv_o)
        else $error("inverted phase did not follow noninverted");

    count_done_idle_a: assert property (res_evt && !ctrl_r.cont
        && cyc_done_r + CW'(1) >= cyc_r
        |=> state_r == mts_pkg::MTS_IDLE && result_o)
        else $error("cycle count reached without going idle");

    sync_meas_a: assert property ($rose(state_r == mts_pkg::MTS_MEAS)
        && ctrl_r.sync_en |-> sync_o)
        else $error("sync low at measurement start");

    delay_start_a: assert property (acc && dly_r > CW'(1)
        |=> state_r == mts_pkg::MTS_WAIT && dly_pend_r ##1 (state_r == mts_pkg::MTS_WAIT
        || $past(cmd_v[`MTS_CMD_ABORT]) || $past(cont_off) || $past(force_v)))
        else $error("trigger delay skipped");

    repeat_result_c: cover property (res_evt && !ctrl_r.moving && avg_r > CW'(1));
    moving_unsettled_c: cover property (result_o && !settled_o);
    counted_single_c: cover property (res_evt && !ctrl_r.cont && cyc_r > CW'(1)
        ##1 state_r == mts_pkg::MTS_WAIT);
    delay_pending_c: cover property (dly_pend_r ##1 state_r == mts_pkg::MTS_MEAS);

endmodule // mts_sequencer

`default_nettype wire

// *** mts_consts.svh ***
// Register map, command bits, reset values and timing counts of the sequencer
`ifndef MTS_CONSTS_SVH
`define MTS_CONSTS_SVH

// Register byte offsets
`define MTS_OFF_CTRL 8'h00
`define MTS_OFF_CMD 8'h04
`define MTS_OFF_CYC 8'h08
`define MTS_OFF_AVG 8'h0C
`define MTS_OFF_APER 8'h10
`define MTS_OFF_DLY 8'h14
`define MTS_OFF_DROP 8'h18
`define MTS_OFF_HOLD 8'h1C
`define MTS_OFF_STAT 8'h20
`define MTS_OFF_RES 8'h24

// Command register bit positions
`define MTS_CMD_INIT 0
`define MTS_CMD_ABORT 1
`define MTS_CMD_FORCE 2
`define MTS_CMD_BUSTRG 3
`define MTS_CMD_W 4

// Control register width and reset value
`define MTS_CTRL_W 7
`define MTS_CTRL_RST 7'h00

// Timing
`define MTS_CLK_MHZ 200
`define MTS_DROPOUT_NS 25
`define MTS_DROPOUT_CYC ((`MTS_DROPOUT_NS * `MTS_CLK_MHZ + 999) / 1000)

// Reset values of the numeric settings
`define MTS_CYC_RST 32'h00000001
`define MTS_AVG_RST 32'h00000001
`define MTS_APER_RST 32'h00000064
`define MTS_DLY_RST 32'h00000000
`define MTS_HOLD_RST 32'h00000000

`endif

// *** mts_pkg.sv ***
// Types shared by the measurement trigger sequencer
`default_nettype none
package mts_pkg;

    typedef enum logic [1:0] {
        MTS_IDLE,
        MTS_WAIT,
        MTS_MEAS
    } mts_state_e;

    typedef enum logic [2:0] {
        MTS_SRC_HOLD,
        MTS_SRC_IMM,
        MTS_SRC_INT,
        MTS_SRC_EXT1,
        MTS_SRC_EXT2,
        MTS_SRC_BUS
    } mts_src_e;

    typedef struct packed {
        mts_src_e src;
        logic slope_neg;
        logic moving;
        logic sync_en;
        logic cont;
    } mts_ctrl_s;

endpackage
`default_nettype wire

// *** mts_host.sv ***
// Remote host model: APB master that sets up the sequencer and sends commands
`timescale 1ns/1ps
`include "mts_consts.svh"
`default_nettype none

module mts_host (
    // Clock
    input wire logic mclk_i,
    // APB master side
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [7:0] paddr_o,
    output logic [31:0] pwdata_o,
    input wire logic [31:0] prdata_i,
    input wire logic pready_i,
    input wire logic pslverr_i
);
    logic err;

    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 8'h00;
        pwdata_o = 32'h0;
        err = 1'b0;
    end

    // Request is held until pready is seen high at an access-phase edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge mclk_i);
        psel_o <= 1'b1;
        penable_o <= 1'b0;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge mclk_i);
        penable_o <= 1'b1;
        do @(posedge mclk_i); while (pready_i !== 1'b1);
        q = prdata_i;
        err = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        xfer(1'b0, a, 32'h0, q);
    endtask

    // Hold and bus sources only ever fire from a command sent here
    task automatic cmd(input int b);
        wr(`MTS_OFF_CMD, 32'h1 << b);
    endtask
endmodule // mts_host
`default_nettype wire

// *** mts_sequencer_tb.sv ***
// Self-checking testbench of the measurement trigger sequencer
`timescale 1ns/1ps
`include "mts_consts.svh"
`default_nettype none

module mts_sequencer_tb;
    logic mclk_i, sys_rst_i, psel, penable, pwrite, pready, pslverr, sync_chk;
    logic sync_o, chop_inv_o, result_o, settled_o;
    logic [1:0] state_o;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [2:0] pins;
    logic setl[$];
    int n_errors, tests_run, n_meas, n_chop, n_res, n_idle, n_sync, cnt;
    logic [7:0] ra[8] = '{`MTS_OFF_CTRL, `MTS_OFF_CMD, `MTS_OFF_CYC, `MTS_OFF_AVG,
                          `MTS_OFF_APER, `MTS_OFF_DLY, `MTS_OFF_DROP, `MTS_OFF_HOLD};
    logic [31:0] rv[8] = '{{25'h0, `MTS_CTRL_RST}, 32'h0, `MTS_CYC_RST, `MTS_AVG_RST,
                           `MTS_APER_RST, `MTS_DLY_RST, 32'(`MTS_DROPOUT_CYC), `MTS_HOLD_RST};

    mts_sequencer dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .int_above_i(pins[2]),
        .ext1_i(pins[0]), .ext2_i(pins[1]), .sync_o(sync_o), .state_o(state_o),
        .chop_inv_o(chop_inv_o), .result_o(result_o), .settled_o(settled_o));

    mts_host host (.mclk_i(mclk_i), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
        .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready),
        .pslverr_i(pslverr));

    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end

    // Observed outputs are sampled before this edge's updates land
    always @(posedge mclk_i) begin
        if (state_o === mts_pkg::MTS_MEAS) n_meas++;
        if (state_o === mts_pkg::MTS_IDLE) n_idle++;
        if (chop_inv_o === 1'b1) n_chop++;
        if (result_o === 1'b1) begin
            n_res++;
            setl.push_back(settled_o);
        end
        if (sync_chk && sync_o !== (state_o === mts_pkg::MTS_MEAS)) n_sync++;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cst(input mts_pkg::mts_state_e s);
        chk({30'h0, state_o}, {30'h0, s});
    endtask

    task automatic wst(input mts_pkg::mts_state_e s);
        cnt = 0;
        while (state_o !== s) begin
            @(negedge mclk_i);
            cnt++;
        end
        @(negedge mclk_i);
    endtask

    task automatic clr;
        @(negedge mclk_i);
        n_meas = 0;
        n_idle = 0;
        n_chop = 0;
        n_res = 0;
        setl.delete();
    endtask

    task automatic pulse(input int w, input int n);
        @(posedge mclk_i);
        pins[w] <= ~pins[w];
        repeat (n) @(posedge mclk_i);
        pins[w] <= ~pins[w];
    endtask

    function automatic logic [31:0] ctl(input mts_pkg::mts_src_e s, input logic mv,
                                        input logic cn);
        mts_pkg::mts_ctrl_s c;
        c.src = s;
        c.slope_neg = 1'b0;
        c.moving = mv;
        c.sync_en = 1'b1;
        c.cont = cn;
        return {25'h0, c};
    endfunction

    task automatic single(input mts_pkg::mts_src_e s, input logic mv);
        host.wr(`MTS_OFF_CTRL, ctl(s, mv, 1'b0));
        clr();
        host.cmd(`MTS_CMD_INIT);
        wst(mts_pkg::MTS_WAIT);
    endtask

    task automatic summarize;
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge mclk_i);
        n_errors++;
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        summarize();
    end

    initial begin
        sys_rst_i = 1'b1;
        pins = 3'b100;
        sync_chk = 1'b0;
        repeat (10) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        @(negedge mclk_i);
        cst(mts_pkg::MTS_IDLE);
        for (int i = 0; i < 8; i++) begin
            host.rd(ra[i], q);
            chk(q, rv[i]);
        end
        host.rd(8'h28, q);
        chk({31'h0, host.err}, 32'h1);
        chk(q, 32'h0);
        // Bus source, one aperture, settled single result
        host.wr(`MTS_OFF_APER, 32'h2);
        sync_chk = 1'b1;
        single(mts_pkg::MTS_SRC_BUS, 1'b0);
        host.cmd(`MTS_CMD_BUSTRG);
        wst(mts_pkg::MTS_IDLE);
        chk(n_meas, 32'h2);
        chk(n_res, 32'h1);
        chk({31'h0, setl[0]}, 32'h1);
        // Hold source ignores bus trigger, force starts it
        single(mts_pkg::MTS_SRC_HOLD, 1'b0);
        host.cmd(`MTS_CMD_BUSTRG);
        repeat (20) @(negedge mclk_i);
        cst(mts_pkg::MTS_WAIT);
        host.cmd(`MTS_CMD_FORCE);
        wst(mts_pkg::MTS_IDLE);
        chk(n_res, 32'h1);
        // Trigger delay
        host.wr(`MTS_OFF_DLY, 32'h8);
        single(mts_pkg::MTS_SRC_BUS, 1'b0);
        host.cmd(`MTS_CMD_BUSTRG);
        wst(mts_pkg::MTS_MEAS);
        chk({31'h0, cnt >= 8 && cnt <= 12}, 32'h1);
        wst(mts_pkg::MTS_IDLE);
        host.wr(`MTS_OFF_DLY, 32'h0);
        // Repeat mode, two measurements of two chopper phases
        host.wr(`MTS_OFF_AVG, 32'h2);
        host.wr(`MTS_OFF_APER, 32'h3);
        single(mts_pkg::MTS_SRC_BUS, 1'b0);
        host.cmd(`MTS_CMD_BUSTRG);
        wst(mts_pkg::MTS_IDLE);
        chk(n_meas, 32'hC);
        chk(n_chop, 32'h6);
        chk(n_res, 32'h1);
        // Moving mode, counted cycles on the first external input
        host.wr(`MTS_OFF_CYC, 32'h3);
        host.wr(`MTS_OFF_APER, 32'h2);
        single(mts_pkg::MTS_SRC_EXT1, 1'b1);
        for (int i = 0; i < 3; i++) begin
            wst(mts_pkg::MTS_WAIT);
            pulse(0, 3);
            while (n_res <= i) @(negedge mclk_i);
        end
        wst(mts_pkg::MTS_IDLE);
        chk(n_res, 32'h3);
        chk(n_meas, 32'hC);
        chk({29'h0, setl[0], setl[1], setl[2]}, 32'h3);
        host.rd(`MTS_OFF_RES, q);
        chk(q, 32'h3);
        host.rd(`MTS_OFF_STAT, q);
        chk(q, 32'h20);
        // Continuous on the second external input with hold-off
        host.wr(`MTS_OFF_CYC, 32'h1);
        host.wr(`MTS_OFF_AVG, 32'h1);
        host.wr(`MTS_OFF_HOLD, 32'h28);
        host.wr(`MTS_OFF_CTRL, ctl(mts_pkg::MTS_SRC_EXT2, 1'b0, 1'b1));
        wst(mts_pkg::MTS_WAIT);
        clr();
        pulse(1, 3);
        while (n_res < 1) @(negedge mclk_i);
        wst(mts_pkg::MTS_WAIT);
        pulse(1, 3);
        repeat (15) @(negedge mclk_i);
        cst(mts_pkg::MTS_WAIT);
        chk(n_res, 32'h1);
        repeat (40) @(negedge mclk_i);
        pulse(1, 3);
        while (n_res < 2) @(negedge mclk_i);
        // Abort in continuous mode, then continuous off
        host.wr(`MTS_OFF_APER, 32'h14);
        wst(mts_pkg::MTS_WAIT);
        repeat (45) @(negedge mclk_i);
        pulse(1, 3);
        wst(mts_pkg::MTS_MEAS);
        host.cmd(`MTS_CMD_ABORT);
        repeat (2) @(negedge mclk_i);
        cst(mts_pkg::MTS_WAIT);
        host.wr(`MTS_OFF_CTRL, ctl(mts_pkg::MTS_SRC_EXT2, 1'b0, 1'b0));
        repeat (2) @(negedge mclk_i);
        cst(mts_pkg::MTS_IDLE);
        host.wr(`MTS_OFF_HOLD, 32'h0);
        // Abort of a single measurement
        single(mts_pkg::MTS_SRC_HOLD, 1'b0);
        host.cmd(`MTS_CMD_FORCE);
        wst(mts_pkg::MTS_MEAS);
        host.cmd(`MTS_CMD_ABORT);
        repeat (2) @(negedge mclk_i);
        cst(mts_pkg::MTS_IDLE);
        chk(n_res, 32'h0);
        // Immediate source running continuously never idles
        host.wr(`MTS_OFF_APER, 32'h2);
        host.wr(`MTS_OFF_CTRL, ctl(mts_pkg::MTS_SRC_IMM, 1'b0, 1'b1));
        wst(mts_pkg::MTS_MEAS);
        clr();
        repeat (60) @(negedge mclk_i);
        chk(n_idle, 32'h0);
        chk({31'h0, n_res > 5}, 32'h1);
        sync_chk = 1'b0;
        host.wr(`MTS_OFF_CTRL, ctl(mts_pkg::MTS_SRC_INT, 1'b0, 1'b0));
        wst(mts_pkg::MTS_IDLE);
        sync_chk = 1'b1;
        // Internal source: short dropout refused, full dropout accepted
        host.cmd(`MTS_CMD_INIT);
        wst(mts_pkg::MTS_WAIT);
        pulse(2, 2);
        repeat (25) @(negedge mclk_i);
        cst(mts_pkg::MTS_WAIT);
        pulse(2, 20);
        wst(mts_pkg::MTS_MEAS);
        chk({31'h0, cnt <= 12}, 32'h1);
        wst(mts_pkg::MTS_IDLE);
        // Negative slope: the falling crossing after a long high level triggers
        host.wr(`MTS_OFF_CTRL, ctl(mts_pkg::MTS_SRC_INT, 1'b0, 1'b0) | 32'h8);
        clr();
        host.cmd(`MTS_CMD_INIT);
        wst(mts_pkg::MTS_WAIT);
        pulse(2, 20);
        repeat (8) @(negedge mclk_i);
        chk(n_res, 32'h1);
        cst(mts_pkg::MTS_IDLE);
        chk(n_sync, 32'h0);
        // Reset in mid-measurement
        host.wr(`MTS_OFF_CTRL, ctl(mts_pkg::MTS_SRC_IMM, 1'b0, 1'b1));
        wst(mts_pkg::MTS_MEAS);
        @(posedge mclk_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(negedge mclk_i);
        cst(mts_pkg::MTS_IDLE);
        chk({31'h0, sync_o}, 32'h0);
        summarize();
    end
endmodule // mts_sequencer_tb
`default_nettype wire
